//--- design/tpl_consts.svh
// Constants of the timer channel pair link control block
//
// Summary of operation
// - Bit 7 reserved, reads zero, ignores writes
// - Bit 6 enables fault control for pair
// - Guarded bits written only when guard disabled
// - Bit 5 enables synchronized match value updates
// - Bit 4 enables deadtime insertion for pair
// - Bit 3 arms captures; needs both enables
// - One-shot mode clears bit 3 after odd capture
// - Bit 2 selects dual capture mode, needs feature
// - Bit 1 makes odd output inverse of even while bit 0 is set
// - Bit 0 combines the pair, else independent
// - Three instances serve channel pairs 0-1, 2-3, 4-5
// - Consecutive bytes from offset 1Eh, one per pair
`ifndef TPL_CONSTS_SVH
`define TPL_CONSTS_SVH
// ==========================================
// Register map
`define TPL_LINK_BASE 8'h1e
`define TPL_NUM_PAIRS 3
`define TPL_ADDR_W 8
// ==========================================
// Field positions
`define TPL_BIT_COMBINE 0
`define TPL_BIT_COMP 1
`define TPL_BIT_DCEN 2
`define TPL_BIT_DCACT 3
`define TPL_BIT_PAIR_DEADTIME_ENABLE 4
`define TPL_BIT_SYNC 5
`define TPL_BIT_FAULT 6
`define TPL_BIT_RSVD 7
// Write-guarded bits: fault, deadtime, mode enable, complement, combine
`define TPL_GUARD_MASK 8'h57
// Writable bits; bit 7 excluded
`define TPL_WR_MASK 8'h7f
`define TPL_RESET_VAL 8'h00
`endif

//--- design/tpl_pair_decode.sv
// Decodes one pair's control byte into the enables driven to the channels
`timescale 1ns/1ps
`include "tpl_consts.svh"
module tpl_pair_decode (
  input wire logic [7:0] value,
  input wire logic advanced_feature_enable,
  input wire logic even_out_raw,
  input wire logic odd_out_raw,
  output logic pair_fault_ctl_enable,
  output logic pair_sync_update_enable,
  output logic pair_deadtime_enable,
  output logic dual_capture_mode_enable,
  output logic dual_capture_active,
  output logic pair_combine,
  output logic odd_out
);
  // ==========================================
  // Enable decode
  always_comb begin
    pair_fault_ctl_enable = value[`TPL_BIT_FAULT];
    pair_sync_update_enable = value[`TPL_BIT_SYNC];
    pair_deadtime_enable = value[`TPL_BIT_PAIR_DEADTIME_ENABLE];
    // Mode only counts with the advanced feature set
    dual_capture_mode_enable = value[`TPL_BIT_DCEN] & advanced_feature_enable;
    dual_capture_active = value[`TPL_BIT_DCACT] & dual_capture_mode_enable;
    pair_combine = value[`TPL_BIT_COMBINE];
    // Independent odd channel unless combined
    if (value[`TPL_BIT_COMBINE]) begin
      odd_out = value[`TPL_BIT_COMP] ? ~even_out_raw : even_out_raw;
    end else begin
      odd_out = odd_out_raw;
    end
  end
endmodule

//--- design/tpl_pair_reg.sv
// One pair's link control byte with write guard and one-shot clear
`timescale 1ns/1ps
`include "tpl_consts.svh"
module tpl_pair_reg (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic write_guard_disable,
  input wire logic one_shot_clear,
  output logic [7:0] value
);
  // All state of this module
  typedef struct packed {
    tpl_pkg::tpl_byte_t val;
  } tpl_reg_state_t;

  tpl_reg_state_t state_q; // Registered state
  tpl_reg_state_t state_d; // Next state
  logic [7:0] wmask; // Bits a write may change

  // ==========================================
  // Next value
  always_comb begin
    state_d = state_q;
    // Guarded bits only while guard is off; other writable bits always
    wmask = write_guard_disable ? `TPL_WR_MASK : (`TPL_WR_MASK & ~`TPL_GUARD_MASK);
    if (wr_en) begin
      state_d.val = (state_q.val & ~wmask) | (wr_data & wmask);
    end
    // Hardware clear wins over a simultaneous software set of bit 3
    if (one_shot_clear) begin
      state_d.val[`TPL_BIT_DCACT] = 1'b0;
    end
    state_d.val[`TPL_BIT_RSVD] = 1'b0;
  end

  // ==========================================
  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q.val <= `TPL_RESET_VAL;
    end else begin
      state_q <= state_d;
    end
  end

  assign value = state_q.val;
endmodule

//--- design/tpl_pkg.sv
// Types of the timer channel pair link control block
package tpl_pkg;
  // One pair's control byte
  typedef logic [7:0] tpl_byte_t;
  // Capture tracking state, Gray coded
  typedef enum logic [1:0] {
    TPL_CAP_IDLE = 2'b00,
    TPL_CAP_EVEN = 2'b01,
    TPL_CAP_DONE = 2'b11
  } tpl_cap_state_t;
endpackage

//--- design/tpl_top.sv
// Top of the timer channel pair link control block: bus slave and pairs
`timescale 1ns/1ps
`include "tpl_consts.svh"
module tpl_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic write_guard_disable,
  input wire logic advanced_feature_enable,
  input wire logic [2:0] one_shot_mode,
  input wire logic [2:0] odd_capture_taken,
  input wire logic [2:0] even_out_raw,
  input wire logic [2:0] odd_out_raw,
  output logic [2:0] pair_fault_ctl_enable,
  output logic [2:0] pair_sync_update_enable,
  output logic [2:0] pair_deadtime_enable,
  output logic [2:0] dual_capture_mode_enable,
  output logic [2:0] dual_capture_active,
  output logic [2:0] pair_combine,
  output logic [2:0] odd_out
);
  // All state of the top
  typedef struct packed {
    logic [7:0] rdata;
  } tpl_top_state_t;

  tpl_top_state_t state_q; // Registered state
  tpl_top_state_t state_d; // Next state
  logic [7:0] pair_val [0:2]; // Stored bytes per pair
  logic [2:0] hit; // Address match per pair

  // ==========================================
  // Per pair register and decode
  genvar gi;
  generate
    for (gi = 0; gi < `TPL_NUM_PAIRS; gi = gi + 1) begin : g_pair
      // Consecutive byte per pair from the base
      assign hit[gi] = (addr == (`TPL_LINK_BASE + 8'(gi)));
      tpl_pair_reg u_reg (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(wr & hit[gi]),
        .wr_data(wdata),
        .write_guard_disable(write_guard_disable),
        // Clear only when armed and effective
        .one_shot_clear(one_shot_mode[gi] & odd_capture_taken[gi] &
                        dual_capture_active[gi]),
        .value(pair_val[gi])
      );
      tpl_pair_decode u_dec (
        .value(pair_val[gi]),
        .advanced_feature_enable(advanced_feature_enable),
        .even_out_raw(even_out_raw[gi]),
        .odd_out_raw(odd_out_raw[gi]),
        .pair_fault_ctl_enable(pair_fault_ctl_enable[gi]),
        .pair_sync_update_enable(pair_sync_update_enable[gi]),
        .pair_deadtime_enable(pair_deadtime_enable[gi]),
        .dual_capture_mode_enable(dual_capture_mode_enable[gi]),
        .dual_capture_active(dual_capture_active[gi]),
        .pair_combine(pair_combine[gi]),
        .odd_out(odd_out[gi])
      );
    end
  endgenerate

  // ==========================================
  // Read path; unmapped addresses read zero
  always_comb begin
    state_d = state_q;
    state_d.rdata = 8'h00;
    if (rd) begin
      for (int i = 0; i < `TPL_NUM_PAIRS; i++) begin
        if (hit[i]) begin
          state_d.rdata = pair_val[i];
        end
      end
    end
  end

  // ==========================================
  // Read data register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q.rdata <= 8'h00;
    end else begin
      state_q <= state_d;
    end
  end

  assign rdata = state_q.rdata;
endmodule

//--- test/test_tpl_top.sv
// Testbench of the pair link control block
`timescale 1ns/1ps
module test_tpl_top;
  logic clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, rd_q = 1'h0;
  logic write_guard_disable = 1'h1, advanced_feature_enable = 1'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
  logic [2:0] one_shot_mode = 3'h0, odd_capture_taken = 3'h0;
  logic [2:0] even_out_raw = 3'h0, odd_out_raw = 3'h0, odd_out, pair_combine;
  logic [2:0] pair_fault_ctl_enable, pair_sync_update_enable, pair_deadtime_enable;
  logic [2:0] dual_capture_mode_enable, dual_capture_active;
  int mismatches = 0, checks = 0;
  logic [7:0] exp_q[$]; // Expected read data, oldest first
  tpl_top uut (.*);
  always #5 clk = ~clk;
  // ====
  // Monitor: read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q) check(rdata, exp_q.pop_front());
  end
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, s, e);
    end
  endtask
  // One bus cycle; a read notes v as its expected data
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] v);
    if (!w) exp_q.push_back(v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'h0;
    rd <= 1'h0;
    #1;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    void'($urandom(18074));
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    // Reset leaves the pair 1 byte at 1Fh at zero
    op(1'h0, 8'h1f, 8'h00);
    // Each pair at its own byte, then a write with the guard closed
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      op(1'h1, 8'h1e + 8'(i), d);
      check(8'({pair_fault_ctl_enable[i], pair_sync_update_enable[i],
        pair_deadtime_enable[i], pair_combine[i]}), 8'({d[6:4], d[0]}));
      op(1'h0, 8'h1e + 8'(i), d & 8'h7f);
      write_guard_disable <= 1'h0;
      op(1'h1, 8'h1e + 8'(i), ~d);
      op(1'h0, 8'h1e + 8'(i), (d & 8'h57) | (~d & 8'h28));
      write_guard_disable <= 1'h1;
    end
    op(1'h0, 8'h1d, 8'h00);
    op(1'h0, 8'h21, 8'h00);
    $display("test map done");
    // One-shot capture clears its own active bit
    // Only pair 0 is driven: pairs 1 and 2 keep random leftovers
    advanced_feature_enable <= 1'h1;
    op(1'h1, 8'h1e, 8'h0c);
    check(8'(dual_capture_active[0]), 8'h01);
    check(8'(dual_capture_mode_enable[0]), 8'h01);
    // Continuous mode: an odd capture leaves the active bit set
    @(posedge clk);
    odd_capture_taken <= 3'h1;
    @(posedge clk);
    odd_capture_taken <= 3'h0;
    #1 check(8'(dual_capture_active[0]), 8'h01);
    one_shot_mode <= 3'h1;
    @(posedge clk);
    odd_capture_taken <= 3'h1;
    @(posedge clk);
    odd_capture_taken <= 3'h0;
    #1 check(8'(dual_capture_active[0]), 8'h00);
    op(1'h0, 8'h1e, 8'h04);
    advanced_feature_enable <= 1'h0;
    #1 check(8'(dual_capture_mode_enable), 8'h00);
    $display("test capture done");
    // Linked odd output: inverse, equal, then independent
    even_out_raw <= 3'h1;
    op(1'h1, 8'h1e, 8'h03);
    check(8'(odd_out[0]), 8'h00);
    op(1'h1, 8'h1e, 8'h01);
    check(8'(odd_out[0]), 8'h01);
    op(1'h1, 8'h1e, 8'h00);
    check(8'(odd_out[0]), 8'h00);
    $display("test link done");
    end_sim;
  end
  // Watchdog: the tests need well under a thousand cycles
  initial begin
    #50000;
    mismatches++;
    end_sim;
  end
endmodule
bind tpl_top tpl_chk chk (.*);

//--- test/tpl_chk.sv
// Assertions on the pair link control ports
`timescale 1ns/1ps
module tpl_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic write_guard_disable,
  input wire logic advanced_feature_enable,
  input wire logic [2:0] one_shot_mode,
  input wire logic [2:0] odd_capture_taken,
  input wire logic [2:0] pair_fault_ctl_enable,
  input wire logic [2:0] pair_sync_update_enable,
  input wire logic [2:0] pair_deadtime_enable,
  input wire logic [2:0] dual_capture_mode_enable,
  input wire logic [2:0] dual_capture_active,
  input wire logic [2:0] pair_combine
);
  // ====
  // Properties, all on the one clock
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rsvd; rd |=> !rdata[7]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("bit 7 set");
  property p_gate; (dual_capture_mode_enable & ~{3{advanced_feature_enable}}) == 3'h0; endproperty
  a_gate: assert property (p_gate) else $error("mode ungated");
  property p_act; (dual_capture_active & ~dual_capture_mode_enable) == 3'h0; endproperty
  a_act: assert property (p_act) else $error("active ungated");
  property p_shot; one_shot_mode[0] && odd_capture_taken[0] && dual_capture_active[0]
    |=> !dual_capture_active[0]; endproperty
  a_shot: assert property (p_shot) else $error("no clear");
  // Guard closed: fault, deadtime and combine outputs may not move a cycle later
  property p_guard; !write_guard_disable
    |=> $stable({pair_fault_ctl_enable, pair_deadtime_enable, pair_combine}); endproperty
  a_guard: assert property (p_guard) else $error("guard leak");
  property p_wr; wr && addr == 8'h1e && write_guard_disable |=> {pair_fault_ctl_enable[0],
    pair_deadtime_enable[0]} == {$past(wdata[6]), $past(wdata[4])}; endproperty
  a_wr: assert property (p_wr) else $error("enable lost");
  property p_sync; wr && addr == 8'h20 |=> pair_sync_update_enable[2] == $past(wdata[5]);
  endproperty
  a_sync: assert property (p_sync) else $error("sync lost");
  property p_unmap; rd && (addr < 8'h1e || addr > 8'h20) |=> rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  c_shot: cover property (odd_capture_taken[0] && dual_capture_active[0]);
  c_guard: cover property (wr && !write_guard_disable);
  c_comb: cover property (pair_combine[0]);
endmodule
